//--- hw/jtbs_tap_top.sv
// Purpose: Boundary-scan test port: TAP controller, instruction, bypass,
//          identification and boundary chain, sampled on the system clock.
// Assumes: TCK is slow against sys_clk_i (at least 4 system cycles per phase).
//          Pad pull-ups hold TDI, TMS and the test reset high when unconnected.
// Notes:   TCK edges become events in a FIFO that the TAP engine drains.
//
// Summary of operation
// [RQ1] TDI is taken on rising TCK.
// [RQ2] Floating TDI reads as one.
// [RQ3] TDO driven only in shift states.
// [RQ4] Floating TMS reads as one.
// [RQ5] Test reset low resets TAP immediately.
// [RQ6] Floating test reset means not asserted.
// [RQ7] TMS on rising TCK steers the TAP.
// [RQ8] State actions happen on rising TCK.
// [RQ9] Instruction register is four bits, serial.
// [RQ10] Instruction shifts apart, applied on update.
// [RQ11] Decode bypass, external test, sample/preload.
// [RQ12] Decode identification, vendor scan, high impedance.
// [RQ13] Bypass puts one bit between TDI/TDO.
// [RQ14] All pin cells form one chain.
// [RQ15] Input cell: one bit, sample and shift.
// [RQ16] Output cell: two stages, drives pin.
// [RQ17] Bidir cell also captures pad, holds drive.
// [RQ18] Reset loads identification and reset state.
// [RQ19] Reset state leaves pins functional; pad data and enables are held at zero while either reset is low.
// [RQ20] Only TMS sequences leave reset state.
// [RQ21] Ten TMS-high cycles clear test logic.
// [RQ22] Unknown opcodes act as bypass.
// [RQ23] High-Z floats outputs; identification selects 32 bits.

module jtbs_fifo #(
    parameter int WIDTH = `JTBS_EV_W,
    parameter int DEPTH = `JTBS_FIFO_DEPTH
) (
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } jtbs_fifo_state_type;

    jtbs_fifo_state_type st_q;
    jtbs_fifo_state_type st_d;
    logic                full;
    logic                empty;

    always_comb
    begin
        full        = (st_q.wr[AW] != st_q.rd[AW]) && (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]);
        empty       = (st_q.wr == st_q.rd);
        in_ready_o  = !full;
        out_valid_o = !empty;
        out_data_o  = st_q.mem[st_q.rd[AW-1:0]];
        st_d        = st_q;
        if (in_valid_i && !full)
        begin
            st_d.mem[st_q.wr[AW-1:0]] = in_data_i;
            st_d.wr                   = st_q.wr + 1'b1;
        end
        if (out_ready_i && !empty)
        begin
            st_d.rd = st_q.rd + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
endmodule

module jtbs_tap_top
    import jtbs_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  trst_n_i,
    input  wire logic                  tck_i,
    input  wire logic                  tms_i,
    input  wire logic                  tdi_i,
    output logic                       tdo_o,
    output logic                       tdo_oe_o,
    input  wire logic [`JTBS_N_IN-1:0] pad_in_i,
    output logic [`JTBS_N_IN-1:0]      core_in_o,
    input  wire logic [`JTBS_N_OUT-1:0] core_out_i,
    output jtbs_obus_type              pad_out_o,
    input  wire jtbs_bbus_type         core_bd_i,
    output jtbs_bbus_type              pad_bd_o,
    input  wire logic [`JTBS_N_BD-1:0] pad_bd_in_i,
    output logic [`JTBS_N_BD-1:0]      core_bd_in_o,
    output logic                       test_active_o,
    output logic                       scan_mode_o
);
    jtbs_state_type st_q;
    jtbs_state_type st_d;
    logic           tap_rst_n;
    logic           ev_in_ready;
    logic           ev_out_valid;
    logic           ev_out_ready;
    jtbs_ev_type    ev_out;
    jtbs_ev_type    ev_now;
    logic           tck_edge;
    logic [`JTBS_CHAIN_LEN-1:0] capture_vec;
    logic           extest;
    logic           highz;

    // Unknown opcodes and the vendor scan opcode fall to the bypass bit
    function automatic jtbs_path_type path_of(input logic [`JTBS_IR_W-1:0] ir);
        jtbs_path_type p;
        p = PATH_BYPASS;
        unique case (ir)
            `JTBS_OP_BYPASS: p = PATH_BYPASS; // RQ11
            `JTBS_OP_EXTEST: p = PATH_CHAIN;  // RQ11
            `JTBS_OP_SAMPLE: p = PATH_CHAIN;  // RQ11
            `JTBS_OP_IDCODE: p = PATH_IDCODE; // RQ12 RQ23
            `JTBS_OP_SCAN:   p = PATH_BYPASS; // RQ12
            `JTBS_OP_HIGHZ:  p = PATH_BYPASS; // RQ12 RQ23
            default:         p = PATH_BYPASS; // RQ22
        endcase
        return p;
    endfunction

    function automatic jtbs_tap_type tap_next(input jtbs_tap_type s, input logic tms);
        jtbs_tap_type n;
        n = TAP_RESET;
        unique case (s)
            TAP_RESET:    n = tms ? TAP_RESET : TAP_IDLE;       // RQ20
            TAP_IDLE:     n = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:   n = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR:   n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: n = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: n = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: n = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR:   n = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR:   n = tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR:   n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: n = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: n = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: n = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR:   n = tms ? TAP_SEL_DR : TAP_IDLE;
            default:      n = TAP_RESET;
        endcase
        return n;
    endfunction

    // Either reset acts at once; the pad pull-up keeps the test reset inactive
    assign tap_rst_n = resetn_i & trst_n_i; // RQ5 RQ6

    // An event waits in a one-entry holding slot while the FIFO is full; edges seen meanwhile are dropped
    jtbs_fifo #(
        .WIDTH (`JTBS_EV_W),
        .DEPTH (`JTBS_FIFO_DEPTH)
    ) u_ev_fifo (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (tap_rst_n),
        .in_valid_i  (st_q.pend_vld),
        .in_ready_o  (ev_in_ready),
        .in_data_i   (st_q.pend),
        .out_valid_o (ev_out_valid),
        .out_ready_i (ev_out_ready),
        .out_data_o  (ev_out)
    );

    // The engine pauses one cycle after each rising event to settle decode
    assign ev_out_ready = !st_q.busy;

    always_comb
    begin
        st_d = st_q;

        st_d.lnk_meta = {tck_i, tms_i, tdi_i};
        st_d.lnk_sync = st_q.lnk_meta;
        st_d.pad_meta = {pad_bd_in_i, pad_in_i};
        st_d.pad_sync = st_q.pad_meta;

        tck_edge      = st_q.lnk_sync[2] ^ st_q.tck_prev;
        st_d.tck_prev = st_q.lnk_sync[2];
        ev_now.rise   = st_q.lnk_sync[2];
        ev_now.tms    = st_q.lnk_sync[1];
        ev_now.tdi    = st_q.lnk_sync[0];
        if (!(st_q.pend_vld && !ev_in_ready))
        begin
            st_d.pend_vld = tck_edge;
            st_d.pend     = ev_now;
        end

        capture_vec = {core_bd_i.oe,
                       st_q.pad_sync[`JTBS_N_IN +: `JTBS_N_BD],
                       core_out_i,
                       st_q.pad_sync[0 +: `JTBS_N_IN]};              // RQ14 RQ15 RQ16 RQ17

        st_d.busy = ev_out_valid && ev_out_ready && ev_out.rise;

        if (ev_out_valid && ev_out_ready)
        begin
            if (ev_out.rise)
            begin
                // Actions of the current state, then the move on the same edge
                unique case (st_q.tap)
                    TAP_CAP_IR:
                    begin
                        st_d.ir_sr = `JTBS_IR_CAPTURE;                           // RQ8
                    end
                    TAP_SHIFT_IR:
                    begin
                        st_d.ir_sr = {ev_out.tdi, st_q.ir_sr[`JTBS_IR_W-1:1]};   // RQ1 RQ9 RQ10
                    end
                    TAP_UPD_IR:
                    begin
                        st_d.ir = st_q.ir_sr;                                    // RQ10
                    end
                    TAP_CAP_DR:
                    begin
                        unique case (path_of(st_q.ir))
                            PATH_BYPASS: st_d.bypass   = 1'b0;
                            PATH_IDCODE: st_d.id_sr    = `JTBS_ID_CODE;          // RQ23
                            PATH_CHAIN:  st_d.chain_sr = capture_vec;            // RQ15 RQ17
                        endcase
                    end
                    TAP_SHIFT_DR:
                    begin
                        unique case (path_of(st_q.ir))
                            PATH_BYPASS: st_d.bypass = ev_out.tdi;               // RQ13 RQ22
                            PATH_IDCODE:
                            begin
                                st_d.id_sr = {ev_out.tdi, st_q.id_sr[`JTBS_ID_W-1:1]};
                            end
                            PATH_CHAIN:
                            begin
                                st_d.chain_sr = {ev_out.tdi,
                                                 st_q.chain_sr[`JTBS_CHAIN_LEN-1:1]}; // RQ14
                            end
                        endcase
                    end
                    TAP_UPD_DR:
                    begin
                        if (path_of(st_q.ir) == PATH_CHAIN)
                        begin
                            st_d.chain_up = st_q.chain_sr;                       // RQ16 RQ17
                        end
                    end
                    default:
                    begin
                        st_d.ir = st_q.ir;
                    end
                endcase

                if (ev_out.tms)
                begin
                    if (st_q.tms_cnt != `JTBS_TMS_CLR)
                    begin
                        st_d.tms_cnt = st_q.tms_cnt + 1'b1;
                    end
                end
                else
                begin
                    st_d.tms_cnt = '0;
                end

                st_d.tap = tap_next(st_q.tap, ev_out.tms);                       // RQ7 RQ8
                if (st_d.tms_cnt == `JTBS_TMS_CLR)
                begin
                    st_d.tap = TAP_RESET;                                        // RQ21
                end
            end
            else
            begin
                // TDO moves on the falling edge; the tester samples it at the end of the next high phase
                unique case (st_q.tap)
                    TAP_SHIFT_IR:
                    begin
                        st_d.tdo    = st_q.ir_sr[0];
                        st_d.tdo_oe = 1'b1;                                      // RQ3
                    end
                    TAP_SHIFT_DR:
                    begin
                        unique case (path_of(st_q.ir))
                            PATH_BYPASS: st_d.tdo = st_q.bypass;                 // RQ13
                            PATH_IDCODE: st_d.tdo = st_q.id_sr[0];
                            PATH_CHAIN:  st_d.tdo = st_q.chain_sr[0];
                        endcase
                        st_d.tdo_oe = 1'b1;                                      // RQ3
                    end
                    default:
                    begin
                        st_d.tdo_oe = 1'b0;                                      // RQ3
                    end
                endcase
            end
        end

        if (st_d.tap == TAP_RESET)
        begin
            st_d.ir = `JTBS_OP_IDCODE;                                           // RQ18 RQ19
        end

        extest = (st_q.ir == `JTBS_OP_EXTEST);
        highz  = (st_q.ir == `JTBS_OP_HIGHZ);

        st_d.core_in    = st_q.pad_sync[0 +: `JTBS_N_IN];
        st_d.core_bd_in = st_q.pad_sync[`JTBS_N_IN +: `JTBS_N_BD];

        // The update stage holds the driven value while the chain shifts
        st_d.pad_out.data = extest ? st_q.chain_up[`JTBS_CH_OUT +: `JTBS_N_OUT]
                                   : core_out_i;                                 // RQ16 RQ19
        st_d.pad_out.oe   = highz ? '0 : '1;                                     // RQ23
        st_d.pad_bd.data  = extest ? st_q.chain_up[`JTBS_CH_BDD +: `JTBS_N_BD]
                                   : core_bd_i.data;                             // RQ17 RQ19
        if (highz)
        begin
            st_d.pad_bd.oe = '0;                                                 // RQ23
        end
        else if (extest)
        begin
            st_d.pad_bd.oe = st_q.chain_up[`JTBS_CH_BDE +: `JTBS_N_BD];          // RQ17
        end
        else
        begin
            st_d.pad_bd.oe = core_bd_i.oe;
        end

        st_d.scan_mode   = (st_q.ir == `JTBS_OP_SCAN);                           // RQ12
        st_d.test_active = (st_q.tap != TAP_RESET);
    end

    always_ff @(posedge sys_clk_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            st_q          <= '0;
            st_q.lnk_meta <= `JTBS_LNK_RST;                                      // RQ2 RQ4
            st_q.lnk_sync <= `JTBS_LNK_RST;                                      // RQ2 RQ4
            st_q.tap      <= TAP_RESET;                                          // RQ5 RQ18
            st_q.ir       <= `JTBS_OP_IDCODE;                                    // RQ18
            st_q.ir_sr    <= `JTBS_OP_IDCODE;
            st_q.pad_out  <= '0;
            st_q.pad_bd   <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign tdo_o         = st_q.tdo;
    assign tdo_oe_o      = st_q.tdo_oe;
    assign core_in_o     = st_q.core_in;
    assign core_bd_in_o  = st_q.core_bd_in;
    assign pad_out_o     = st_q.pad_out;
    assign pad_bd_o      = st_q.pad_bd;
    assign test_active_o = st_q.test_active;
    assign scan_mode_o   = st_q.scan_mode;
endmodule

//--- hw/jtbs_cfg.svh
// Purpose: Constants of the boundary-scan test port.
// Assumes: Included by bare name from the package, the checker and the bench.
// Notes:   Opcodes, cell counts, chain layout and counts.
`ifndef JTBS_CFG_SVH
`define JTBS_CFG_SVH

`define JTBS_IR_W        4
`define JTBS_OP_BYPASS   4'hf
`define JTBS_OP_EXTEST   4'h0
`define JTBS_OP_SAMPLE   4'h4
`define JTBS_OP_IDCODE   4'hd
`define JTBS_OP_SCAN     4'h7
`define JTBS_OP_HIGHZ    4'h5
`define JTBS_IR_CAPTURE  4'h1

// Identification value is arbitrary; bit 0 is one as the scan convention needs
`define JTBS_ID_W        32
`define JTBS_ID_CODE     32'h0a5a_5001

`define JTBS_N_IN        2
`define JTBS_N_OUT       2
`define JTBS_N_BD        2
`define JTBS_CH_IN       0
`define JTBS_CH_OUT      (`JTBS_CH_IN + `JTBS_N_IN)
`define JTBS_CH_BDD      (`JTBS_CH_OUT + `JTBS_N_OUT)
`define JTBS_CH_BDE      (`JTBS_CH_BDD + `JTBS_N_BD)
`define JTBS_CHAIN_LEN   (`JTBS_CH_BDE + `JTBS_N_BD)

`define JTBS_LNK_RST     3'b011
`define JTBS_TMS_CLR     4'd10
`define JTBS_CNT_W       4
`define JTBS_EV_W        3
`define JTBS_FIFO_DEPTH  32

`endif

//--- hw/jtbs_pkg.sv
// Purpose: Types of the boundary-scan test port.
// Assumes: Constants come from the configuration header.
// Notes:   One-hot TAP states and one-hot scan path selection.
package jtbs_pkg;

`include "jtbs_cfg.svh"

    typedef enum logic [15:0] {
        TAP_RESET    = 16'h0001,
        TAP_IDLE     = 16'h0002,
        TAP_SEL_DR   = 16'h0004,
        TAP_CAP_DR   = 16'h0008,
        TAP_SHIFT_DR = 16'h0010,
        TAP_EXIT1_DR = 16'h0020,
        TAP_PAUSE_DR = 16'h0040,
        TAP_EXIT2_DR = 16'h0080,
        TAP_UPD_DR   = 16'h0100,
        TAP_SEL_IR   = 16'h0200,
        TAP_CAP_IR   = 16'h0400,
        TAP_SHIFT_IR = 16'h0800,
        TAP_EXIT1_IR = 16'h1000,
        TAP_PAUSE_IR = 16'h2000,
        TAP_EXIT2_IR = 16'h4000,
        TAP_UPD_IR   = 16'h8000
    } jtbs_tap_type;

    typedef enum logic [2:0] {
        PATH_BYPASS = 3'h1,
        PATH_IDCODE = 3'h2,
        PATH_CHAIN  = 3'h4
    } jtbs_path_type;

    typedef struct packed {
        logic rise;
        logic tms;
        logic tdi;
    } jtbs_ev_type;

    typedef struct packed {
        logic [`JTBS_N_OUT-1:0] data;
        logic [`JTBS_N_OUT-1:0] oe;
    } jtbs_obus_type;

    typedef struct packed {
        logic [`JTBS_N_BD-1:0] data;
        logic [`JTBS_N_BD-1:0] oe;
    } jtbs_bbus_type;

    typedef struct packed {
        logic [2:0]                      lnk_meta;
        logic [2:0]                      lnk_sync;
        logic [`JTBS_N_IN+`JTBS_N_BD-1:0] pad_meta;
        logic [`JTBS_N_IN+`JTBS_N_BD-1:0] pad_sync;
        logic                            tck_prev;
        logic                            pend_vld;
        jtbs_ev_type                     pend;
        logic                            busy;
        jtbs_tap_type                    tap;
        logic [`JTBS_IR_W-1:0]           ir_sr;
        logic [`JTBS_IR_W-1:0]           ir;
        logic                            bypass;
        logic [`JTBS_ID_W-1:0]           id_sr;
        logic [`JTBS_CHAIN_LEN-1:0]      chain_sr;
        logic [`JTBS_CHAIN_LEN-1:0]      chain_up;
        logic [`JTBS_CNT_W-1:0]          tms_cnt;
        logic                            tdo;
        logic                            tdo_oe;
        logic [`JTBS_N_IN-1:0]           core_in;
        logic [`JTBS_N_BD-1:0]           core_bd_in;
        jtbs_obus_type                   pad_out;
        jtbs_bbus_type                   pad_bd;
        logic                            scan_mode;
        logic                            test_active;
    } jtbs_state_type;

endpackage

//--- sim/jtbs_tap_sva.sv
// Purpose: Checker for the boundary-scan test port, bound to its top module.
// Assumes: TCK phases last at least four system cycles.
// Notes:   Sees only the top module's ports.
`include "jtbs_cfg.svh"

module jtbs_tap_sva
    import jtbs_pkg::*;
(
    input wire logic                    sys_clk_i,
    input wire logic                    resetn_i,
    input wire logic                    trst_n_i,
    input wire logic                    tck_i,
    input wire logic                    tdo_o,
    input wire logic                    tdo_oe_o,
    input wire logic [`JTBS_N_IN-1:0]   pad_in_i,
    input wire logic [`JTBS_N_IN-1:0]   core_in_o,
    input wire logic [`JTBS_N_OUT-1:0]  core_out_i,
    input wire jtbs_obus_type           pad_out_o,
    input wire jtbs_bbus_type           core_bd_i,
    input wire jtbs_bbus_type           pad_bd_o,
    input wire logic [`JTBS_N_BD-1:0]   pad_bd_in_i,
    input wire logic [`JTBS_N_BD-1:0]   core_bd_in_o,
    input wire logic                    test_active_o,
    input wire logic                    scan_mode_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    trst_reset_a: assert property (!trst_n_i |-> !test_active_o && !tdo_oe_o
        && !scan_mode_o && pad_out_o.oe == 2'h0 && pad_bd_o.oe == 2'h0)
        else $error("Test reset left the port active");
    pins_func_a: assert property ((!test_active_o && trst_n_i) [*2] ##1 trst_n_i |->
        pad_out_o == {$past(core_out_i), 2'h3} && pad_bd_o == $past(core_bd_i))
        else $error("Pins not functional in reset state");
    oe_hold_a: assert property (disable iff (!resetn_i || !trst_n_i)
        $rose(tdo_oe_o) |=> tdo_oe_o [*7])
        else $error("Output enable shorter than one test clock");
    tdo_hold_a: assert property (disable iff (!resetn_i || !trst_n_i)
        $changed(tdo_o) |=> $stable(tdo_o) [*7])
        else $error("Serial output changed twice in one test clock");
    active_tck_a: assert property ($rose(test_active_o) |-> $past(tck_i, 5))
        else $error("Reset state left without a rising test clock");
    scan_rise_a: assert property ($rose(scan_mode_o) |-> $past(tck_i, 5)
        && test_active_o)
        else $error("Scan mode set outside an update");
    oe_active_a: assert property (tdo_oe_o |-> test_active_o)
        else $error("Serial output enabled in reset state");
    pins_test_a: assert property (pad_out_o.oe != 2'h3 && trst_n_i && $past(trst_n_i)
        && $past(resetn_i) |-> test_active_o)
        else $error("Output pins released in reset state");
    core_in_a: assert property (disable iff (!resetn_i || !trst_n_i)
        ($stable(pad_in_i) && $stable(pad_bd_in_i)) [*5] |->
        core_in_o == pad_in_i && core_bd_in_o == pad_bd_in_i)
        else $error("Pad levels not passed to the core");

    cover property ($rose(tdo_oe_o));
    cover property ($rose(scan_mode_o));
    cover property ($fell(test_active_o) && trst_n_i);
endmodule

bind jtbs_tap_top jtbs_tap_sva u_sva (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .trst_n_i(trst_n_i), .tck_i(tck_i),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pad_in_i(pad_in_i), .core_in_o(core_in_o),
    .core_out_i(core_out_i), .pad_out_o(pad_out_o), .core_bd_i(core_bd_i),
    .pad_bd_o(pad_bd_o), .pad_bd_in_i(pad_bd_in_i), .core_bd_in_o(core_bd_in_o),
    .test_active_o(test_active_o), .scan_mode_o(scan_mode_o)
);

//--- sim/jtbs_tester.sv
// Purpose: Boundary-scan tester model driving the test port.
// Assumes: Tasks are entered at a rising system clock edge.
// Notes:   TCK idles low between frames; each phase lasts four system cycles.
module jtbs_tester (
    input  wire logic sys_clk_i,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // TMS and TDI change with the falling edge, so they are settled around the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (4) @(posedge sys_clk_i);
        tck_o <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        tdo = tdo_oe_i ? tdo_i : 1'b1;
        tck_o <= 1'b0;
    endtask

    task automatic walk(input logic [9:0] tms, input int n);
        logic d;
        for (int i = 0; i < n; i++)
            step(tms[i], 1'b1, d);
    endtask

    // Scan n bits LSB first from Idle, back to Idle through Update
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] dout);
        logic d;
        dout = '0;
        walk(ir ? 10'h003 : 10'h001, ir ? 4 : 3);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], d);
            dout[i] = d;
        end
        walk(10'h001, 2);
    endtask
endmodule

//--- sim/tb_top.sv
// Purpose: Self-checking bench of the boundary-scan test port.
// Assumes: The tester model makes TCK at 320 ns from the system clock.
// Notes:   Pad and core inputs hold fixed values unless a test changes them.
`include "jtbs_cfg.svh"

module tb_top
    import jtbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          sys_clk, resetn, trst_n, tck, tms, tdi, tdo, tdo_oe;
    logic          test_active, scan_mode;
    logic [1:0]    pad_in, core_in, core_out, pad_bd_in, core_bd_in;
    jtbs_obus_type pad_out;
    jtbs_bbus_type core_bd, pad_bd;
    logic [31:0]   q;
    int            err_count, n_tests;

    jtbs_tap_top uut (.sys_clk_i(sys_clk), .resetn_i(resetn), .trst_n_i(trst_n), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pad_in_i(pad_in),
        .core_in_o(core_in), .core_out_i(core_out), .pad_out_o(pad_out), .core_bd_i(core_bd),
        .pad_bd_o(pad_bd), .pad_bd_in_i(pad_bd_in), .core_bd_in_o(core_bd_in),
        .test_active_o(test_active), .scan_mode_o(scan_mode));
    jtbs_tester u_tester (.sys_clk_i(sys_clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
        .tms_o(tms), .tdi_o(tdi));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("Compares %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Lets the last TCK edge work through the synchroniser and event queue
    task automatic settle();
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic ir(input logic [3:0] op);
        u_tester.scan(1'b1, {28'h0, op}, 4, q);
        check(q, 32'h1);
        settle();
    endtask

    task automatic dr(input logic [31:0] din, input int n);
        u_tester.scan(1'b0, din, n, q);
        settle();
    endtask

    task automatic pins_func();
        check(pad_out, {core_out, 2'h3});
        check(pad_bd, core_bd);
    endtask

    task automatic t_reset_id();
        pins_func();
        check(test_active, 1'b0);
        u_tester.walk(10'h007, 3);
        settle();
        check(test_active, 1'b0);
        u_tester.walk(10'h000, 1);
        settle();
        check(test_active, 1'b1);
        dr(32'hffff_ffff, 32);
        check(q, `JTBS_ID_CODE);
        $display("Test reset_id done");
    endtask

    task automatic t_bypass();
        logic [3:0] ops [4];
        ops = '{`JTBS_OP_BYPASS, `JTBS_OP_SCAN, `JTBS_OP_HIGHZ, 4'h3};
        foreach (ops[i])
        begin
            ir(ops[i]);
            check(scan_mode, ops[i] == `JTBS_OP_SCAN);
            check(pad_out.oe, ops[i] == `JTBS_OP_HIGHZ ? 2'h0 : 2'h3);
            check(pad_bd.oe, ops[i] == `JTBS_OP_HIGHZ ? 2'h0 : core_bd.oe);
            dr(32'h5b, 8);
            check(q, 32'hb6);
        end
        $display("Test bypass done");
    endtask

    task automatic t_boundary();
        ir(`JTBS_OP_SAMPLE);
        pins_func();
        dr(32'hb6, 8);
        check(q, {core_bd.oe, pad_bd_in, core_out, pad_in});
        ir(`JTBS_OP_EXTEST);
        check(pad_out, 4'h7);
        check(pad_bd, 4'he);
        core_out <= ~core_out;
        pad_in <= 2'h1;
        pad_bd_in <= 2'h3;
        settle();
        check(pad_out, 4'h7);
        check(core_in, pad_in);
        check(core_bd_in, pad_bd_in);
        dr(32'h0, 8);
        check(q, {core_bd.oe, pad_bd_in, core_out, pad_in});
        check(pad_out, 4'h3);
        check(pad_bd, 4'h0);
        $display("Test boundary done");
    endtask

    task automatic t_tms_clear();
        u_tester.walk(10'h001, 3);
        u_tester.walk(10'h3ff, 10);
        settle();
        check(test_active, 1'b0);
        pins_func();
        u_tester.walk(10'h000, 1);
        dr(32'h0, 32);
        check(q, `JTBS_ID_CODE);
        $display("Test tms_clear done");
    endtask

    task automatic t_trst();
        ir(`JTBS_OP_SCAN);
        trst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(test_active, 1'b0);
        check(scan_mode, 1'b0);
        trst_n <= 1'b1;
        settle();
        check(test_active, 1'b0);
        pins_func();
        u_tester.walk(10'h000, 1);
        dr(32'h0, 32);
        check(q, `JTBS_ID_CODE);
        $display("Test trst done");
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial
    begin
        resetn = 1'b0;
        trst_n = 1'b1;
        pad_in = 2'h2;
        core_out = 2'h1;
        pad_bd_in = 2'h2;
        core_bd = 4'h6;
        err_count = 0;
        n_tests = 0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        settle();
        t_reset_id();
        t_bypass();
        t_boundary();
        t_tms_clear();
        t_trst();
        end_sim();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        end_sim();
    end
endmodule
